// [rtl/rbp_boot_protect.sv]
`timescale 1ns/100ps
`default_nettype none

module rbp_boot_protect #(
  parameter int NVM_SIZE = rbp_pkg::NVM_SIZE,
  parameter int NVM_ADDR_W = rbp_pkg::NVM_ADDR_W,
  parameter int VENDOR_BYTES = rbp_pkg::NVM_VENDOR_BYTES,
  parameter int FACTORY_BYTES = 1024
) (
  input wire logic i_clock,
  input wire logic i_reset,
  // Boot control
  input wire logic i_boot_start,
  input wire logic [2:0] i_program_level,
  input wire logic i_retest_entry,
  output logic o_boot_busy,
  output logic o_boot_done,
  // Boot fetch of the protection byte
  output logic o_nvm_fetch_req,
  output logic [NVM_ADDR_W-1:0] o_nvm_fetch_addr,
  input wire logic i_nvm_fetch_valid,
  input wire logic [7:0] i_nvm_fetch_data,
  // User load handshake
  output logic o_user_load_req,
  input wire logic i_user_load_done,
  output logic o_user_run,
  // RAM clear writes (data is always zero)
  output logic o_ram_clear_valid,
  output logic o_ram_clear_iram,
  output logic [11:0] o_ram_clear_addr,
  input wire logic i_ram_clear_ready,
  // Protection results
  output logic o_early_oscillator_enable,
  output logic o_eeprom_block,
  output logic o_nvm_block,
  output logic o_two_wire_debug_port_open,
  // EEPROM access filter
  input wire logic i_eeprom_wr_req,
  output logic o_eeprom_wr_en,
  input wire logic [7:0] i_eeprom_rd_data,
  output logic [7:0] o_eeprom_rd_data,
  // Memory access gate
  input wire logic i_acc_req,
  input wire logic [1:0] i_acc_op,
  input wire logic [NVM_ADDR_W-1:0] i_acc_addr,
  output logic o_acc_grant,
  output logic o_acc_deny,
  // Protection byte programming
  input wire logic i_prot_prog_req,
  input wire logic [7:0] i_prot_prog_bits,
  output logic o_prot_nvm_wr_req,
  output logic [NVM_ADDR_W-1:0] o_prot_nvm_wr_addr,
  output logic [7:0] o_prot_nvm_wr_data,
  output logic o_prot_prog_done,
  output logic o_prot_prog_reject
);

  if (VENDOR_BYTES + FACTORY_BYTES >= NVM_SIZE || (1 << NVM_ADDR_W) != NVM_SIZE)
  begin : g_bad_params
    $error("rbp_boot_protect: memory layout does not fit");
  end

  localparam logic [NVM_ADDR_W-1:0] VENDOR_BASE = NVM_ADDR_W'(NVM_SIZE - VENDOR_BYTES);
  localparam logic [NVM_ADDR_W-1:0] BYTE_ADDR = NVM_ADDR_W'(rbp_pkg::PROT_BYTE_ADDR);

  // Set-only merge of programmed bits
  function automatic logic [7:0] set_only(input logic [7:0] held, input logic [7:0] add);
    set_only = held | add;
  endfunction

  rbp_pkg::rbp_state_t state;
  rbp_pkg::rbp_state_t next_state;
  logic [7:0] prot_byte;
  logic retest;
  logic osc_en;
  logic eeprom_block;
  logic nvm_block;
  logic debug_open;
  logic user_run;
  logic boot_done;
  logic clear_start;
  logic load_req;
  logic [7:0] eeprom_rd;
  logic prog_wr;
  logic [7:0] prog_data;
  logic prog_done;
  logic prog_reject;

  // Level decode
  wire logic level_run = (i_program_level == rbp_pkg::LEVEL_RUN);
  wire logic level_user = (i_program_level == rbp_pkg::LEVEL_USER);

  // Fetched byte with reserved bits dropped
  wire logic [7:0] fetched = i_nvm_fetch_data & rbp_pkg::PROT_BYTE_USED_MASK;
  wire logic f_nvm_lock = fetched[rbp_pkg::BIT_NVM_LOCK];
  wire logic f_eeprom_lock = fetched[rbp_pkg::BIT_EEPROM_LOCK];
  wire logic f_ram_clear = fetched[rbp_pkg::BIT_RAM_CLEAR];
  wire logic f_early_osc = fetched[rbp_pkg::BIT_EARLY_OSC];
  wire logic retest_now = i_retest_entry & level_run;

  // Held flags for later states
  wire logic h_nvm_lock = prot_byte[rbp_pkg::BIT_NVM_LOCK];
  wire logic h_ram_clear = prot_byte[rbp_pkg::BIT_RAM_CLEAR];
  wire logic h_auto_run = prot_byte[rbp_pkg::BIT_AUTO_RUN];
  wire logic clear_done;
  wire logic fetch_hit = (state == rbp_pkg::RBP_FETCH) & i_nvm_fetch_valid;

  // Boot sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      rbp_pkg::RBP_IDLE:
        if (i_boot_start)
          next_state = rbp_pkg::RBP_FETCH;
      rbp_pkg::RBP_FETCH:
        if (i_nvm_fetch_valid)
        begin
          if (retest_now)
            next_state = f_ram_clear ? rbp_pkg::RBP_CLEAR : rbp_pkg::RBP_LOCK;
          else if (level_user)
            next_state = rbp_pkg::RBP_LOAD;
          else
            next_state = rbp_pkg::RBP_DONE;
        end
      rbp_pkg::RBP_CLEAR:
        if (clear_done)
          next_state = rbp_pkg::RBP_LOCK;
      rbp_pkg::RBP_LOAD:
        if (i_user_load_done)
          next_state = rbp_pkg::RBP_DONE;
      rbp_pkg::RBP_LOCK:
        next_state = rbp_pkg::RBP_DONE;
      rbp_pkg::RBP_DONE:
        if (i_boot_start)
          next_state = rbp_pkg::RBP_FETCH;
      default:
        next_state = rbp_pkg::RBP_IDLE;
    endcase
  end

  // Sequencer state and captured byte; the byte never leaves this module
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state <= rbp_pkg::RBP_IDLE;
      prot_byte <= rbp_pkg::PROT_BYTE_RESET;
      retest <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (fetch_hit)
      begin
        prot_byte <= fetched;
        retest <= retest_now;
      end
    end
  end

  // Protection outputs, set by boot and held until the next boot
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      osc_en <= 1'b0;
      eeprom_block <= 1'b0;
      nvm_block <= 1'b0;
      debug_open <= 1'b0;
      user_run <= 1'b0;
    end
    else if (state == rbp_pkg::RBP_IDLE || state == rbp_pkg::RBP_DONE)
    begin
      if (i_boot_start)
      begin
        eeprom_block <= 1'b0;
        nvm_block <= 1'b0;
        debug_open <= 1'b0;
        user_run <= 1'b0;
      end
    end
    else
    begin
      if (fetch_hit)
      begin
        osc_en <= f_early_osc;
        eeprom_block <= retest_now & f_eeprom_lock;
      end
      if (state == rbp_pkg::RBP_LOCK)
      begin
        nvm_block <= h_nvm_lock;
        debug_open <= 1'b1;
      end
      if (state == rbp_pkg::RBP_LOAD && i_user_load_done)
        user_run <= h_auto_run;
    end
  end

  // One-cycle boot pulses and requests
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      boot_done <= 1'b0;
      clear_start <= 1'b0;
      load_req <= 1'b0;
    end
    else
    begin
      boot_done <= (next_state == rbp_pkg::RBP_DONE) & (state != rbp_pkg::RBP_DONE);
      clear_start <= fetch_hit & retest_now & f_ram_clear;
      load_req <= (next_state == rbp_pkg::RBP_LOAD) & (state != rbp_pkg::RBP_LOAD);
    end
  end

  // Zero fill of code RAM and IRAM
  rbp_zero_fill #(
    .CODE_SIZE(rbp_pkg::CODE_RAM_SIZE),
    .CODE_KEEP(rbp_pkg::CODE_FACTORY_BYTES),
    .IRAM_SIZE(rbp_pkg::IRAM_SIZE),
    .IRAM_KEEP(rbp_pkg::IRAM_KEEP_REGS),
    .ADDR_W(12)
  ) u_fill (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_start(clear_start),
    .i_wr_ready(i_ram_clear_ready),
    .o_wr_valid(o_ram_clear_valid),
    .o_wr_iram(o_ram_clear_iram),
    .o_wr_addr(o_ram_clear_addr),
    .o_done(clear_done)
  );

  // EEPROM filter: blocked reads give zero, writes dropped
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      eeprom_rd <= 8'h00;
    else
      eeprom_rd <= eeprom_block ? rbp_pkg::EEPROM_BLOCKED_READ : i_eeprom_rd_data;
  end
  assign o_eeprom_wr_en = i_eeprom_wr_req & ~eeprom_block;

  // Memory access gate
  wire logic op_read = (i_acc_op == rbp_pkg::RBP_OP_READ);
  wire logic op_crc = (i_acc_op == rbp_pkg::RBP_OP_CRC_FACTORY)
    | (i_acc_op == rbp_pkg::RBP_OP_CRC_USER);
  wire logic in_vendor = (i_acc_addr >= VENDOR_BASE);
  wire logic locked_ok = op_crc | (op_read & in_vendor);
  wire logic acc_ok = ~nvm_block | locked_ok;
  assign o_acc_grant = i_acc_req & acc_ok;
  assign o_acc_deny = i_acc_req & ~acc_ok;

  // Protection byte programming: set-only, refused at run level
  wire logic prog_refused = level_run;
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      prog_wr <= 1'b0;
      prog_data <= 8'h00;
      prog_done <= 1'b0;
      prog_reject <= 1'b0;
    end
    else
    begin
      prog_wr <= i_prot_prog_req & ~prog_refused;
      prog_done <= i_prot_prog_req & ~prog_refused;
      prog_reject <= i_prot_prog_req & prog_refused;
      if (i_prot_prog_req & ~prog_refused)
        prog_data <= set_only(8'h00, i_prot_prog_bits);
    end
  end

  // Output assignments
  assign o_boot_busy = (state != rbp_pkg::RBP_IDLE) & (state != rbp_pkg::RBP_DONE);
  assign o_boot_done = boot_done;
  assign o_nvm_fetch_req = (state == rbp_pkg::RBP_FETCH);
  assign o_nvm_fetch_addr = BYTE_ADDR;
  assign o_user_load_req = load_req;
  assign o_user_run = user_run;
  assign o_early_oscillator_enable = osc_en;
  assign o_eeprom_block = eeprom_block;
  assign o_nvm_block = nvm_block;
  assign o_two_wire_debug_port_open = debug_open & retest;
  assign o_eeprom_rd_data = eeprom_rd;
  assign o_prot_nvm_wr_req = prog_wr;
  assign o_prot_nvm_wr_addr = BYTE_ADDR;
  assign o_prot_nvm_wr_data = prog_data;
  assign o_prot_prog_done = prog_done;
  assign o_prot_prog_reject = prog_reject;

endmodule

`default_nettype wire

// [include/rbp_pkg.sv]
package rbp_pkg;

  // Program level encodings
  localparam logic [2:0] LEVEL_FACTORY = 3'h1;
  localparam logic [2:0] LEVEL_USER = 3'h3;
  localparam logic [2:0] LEVEL_RUN = 3'h7;

  // Protection byte field positions
  localparam int BIT_NVM_LOCK = 7;
  localparam int BIT_EEPROM_LOCK = 6;
  localparam int BIT_RAM_CLEAR = 5;
  localparam int BIT_EARLY_OSC = 4;
  localparam int BIT_AUTO_RUN = 1;
  localparam logic [7:0] PROT_BYTE_USED_MASK = 8'hf2;
  localparam logic [7:0] PROT_BYTE_RESET = 8'h00;

  // Non-volatile memory layout (byte addresses)
  localparam int NVM_ADDR_W = 13;
  localparam int NVM_SIZE = 8192;
  localparam logic [12:0] PROT_BYTE_ADDR = 13'h0000;
  localparam int NVM_VENDOR_BYTES = 64;

  // RAM layout
  localparam int CODE_RAM_SIZE = 4096;
  localparam int CODE_FACTORY_BYTES = 256;
  localparam int IRAM_SIZE = 256;
  localparam int IRAM_KEEP_REGS = 8;
  localparam logic [7:0] EEPROM_BLOCKED_READ = 8'h00;

  // Memory operations presented to the access gate
  typedef enum logic [1:0] {
    RBP_OP_READ = 2'h0,
    RBP_OP_WRITE = 2'h1,
    RBP_OP_CRC_FACTORY = 2'h2,
    RBP_OP_CRC_USER = 2'h3
  } rbp_op_t;

  // Boot sequencer states, Gray coded in declaration order
  typedef enum logic [2:0] {
    RBP_IDLE = 3'h0,
    RBP_FETCH = 3'h1,
    RBP_CLEAR = 3'h3,
    RBP_LOAD = 3'h2,
    RBP_LOCK = 3'h6,
    RBP_DONE = 3'h7
  } rbp_state_t;

endpackage

// [rtl/rbp_zero_fill.sv]
`timescale 1ns/100ps
`default_nettype none

module rbp_zero_fill #(
  parameter int CODE_SIZE = rbp_pkg::CODE_RAM_SIZE,
  parameter int CODE_KEEP = rbp_pkg::CODE_FACTORY_BYTES,
  parameter int IRAM_SIZE = rbp_pkg::IRAM_SIZE,
  parameter int IRAM_KEEP = rbp_pkg::IRAM_KEEP_REGS,
  parameter int ADDR_W = 12
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic i_wr_ready,
  output logic o_wr_valid,
  output logic o_wr_iram,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic o_done
);

  if (CODE_KEEP >= CODE_SIZE || IRAM_KEEP >= IRAM_SIZE || (1 << ADDR_W) < CODE_SIZE
      || (1 << ADDR_W) < IRAM_SIZE)
  begin : g_bad_params
    $error("rbp_zero_fill: region sizes do not fit");
  end

  localparam logic [ADDR_W-1:0] CODE_LAST = ADDR_W'(CODE_SIZE - CODE_KEEP - 1);
  localparam logic [ADDR_W-1:0] IRAM_FIRST = ADDR_W'(IRAM_KEEP);
  localparam logic [ADDR_W-1:0] IRAM_LAST = ADDR_W'(IRAM_SIZE - 1);

  logic busy;
  logic iram;
  logic [ADDR_W-1:0] addr;
  logic done;

  // Step decode: one zero write taken per ready cycle
  wire logic step = busy & i_wr_ready;
  wire logic code_end = ~iram & (addr == CODE_LAST);
  wire logic iram_end = iram & (addr == IRAM_LAST);

  // Walk code RAM below the factory region, then IRAM above the kept registers
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      busy <= 1'b0;
      iram <= 1'b0;
      addr <= '0;
      done <= 1'b0;
    end
    else
    begin
      done <= step & iram_end;
      if (i_start & ~busy)
      begin
        busy <= 1'b1;
        iram <= 1'b0;
        addr <= '0;
      end
      else if (step)
      begin
        if (code_end)
        begin
          iram <= 1'b1;
          addr <= IRAM_FIRST;
        end
        else if (iram_end)
          busy <= 1'b0;
        else
          addr <= addr + ADDR_W'(1);
      end
    end
  end

  assign o_wr_valid = busy;
  assign o_wr_iram = iram;
  assign o_wr_addr = addr;
  assign o_done = done;

endmodule

`default_nettype wire

// [verif/rbp_nvm_model.sv]
`timescale 1ns/100ps
`default_nettype none

module rbp_nvm_model (
  input wire logic i_clock,
  input wire logic i_slow,
  input wire logic i_fetch,
  input wire logic [12:0] i_addr,
  output logic o_valid,
  output logic [7:0] o_data,
  input wire logic i_load,
  output logic o_load_done,
  input wire logic i_clr,
  input wire logic i_clr_iram,
  input wire logic [11:0] i_clr_addr,
  output logic o_ready,
  input wire logic i_wr,
  input wire logic [12:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_cells,
  output var int o_clears,
  output var int o_bad
);
  int wait_n;
  int load_n;

  // Blank memory; the cell is never cleared afterwards
  initial
  begin
    {o_valid, o_load_done, o_ready, o_cells, o_data} = '0;
    {o_clears, o_bad, wait_n, load_n} = '0;
  end

  // Fetch answer, load ack, zero-fill acceptance, one-way cell writes
  always @(posedge i_clock)
  begin
    o_valid <= 1'b0;
    o_load_done <= 1'b0;
    o_ready <= !i_slow || !o_ready;
    o_data <= ~o_data;
    if (i_fetch && !o_valid)
      wait_n <= wait_n + 1;
    if (i_fetch && !o_valid && wait_n >= (i_slow ? 6 : 1))
    begin
      wait_n <= 0;
      o_valid <= 1'b1;
      o_data <= (i_addr == 13'h0000) ? o_cells : 8'hff;
    end
    if (i_load)
      load_n <= 3;
    else if (load_n != 0)
      load_n <= load_n - 1;
    if (load_n == 1)
      o_load_done <= 1'b1;
    if (i_clr && o_ready)
    begin
      o_clears <= o_clears + 1;
      if ({i_clr_iram, i_clr_addr} != (o_clears < 3840 ? 13'(o_clears) : 13'(o_clears + 264)))
        o_bad <= o_bad + 1;
    end
    if (i_wr && i_wr_addr == 13'h0000)
      o_cells <= o_cells | i_wr_data;
  end
endmodule

`default_nettype wire

// [verif/rbp_boot_protect_chk.sv]
`timescale 1ns/100ps
`default_nettype none

module rbp_boot_protect_chk (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [2:0] i_program_level,
  input wire logic i_retest_entry,
  input wire logic o_boot_busy,
  input wire logic o_boot_done,
  input wire logic o_nvm_fetch_req,
  input wire logic i_nvm_fetch_valid,
  input wire logic [7:0] i_nvm_fetch_data,
  input wire logic o_early_oscillator_enable,
  input wire logic o_eeprom_block,
  input wire logic o_nvm_block,
  input wire logic i_eeprom_wr_req,
  input wire logic o_eeprom_wr_en,
  input wire logic i_acc_req,
  input wire logic [1:0] i_acc_op,
  input wire logic [12:0] i_acc_addr,
  input wire logic o_acc_grant,
  input wire logic o_acc_deny,
  input wire logic i_prot_prog_req,
  input wire logic [7:0] i_prot_prog_bits,
  input wire logic [7:0] o_prot_nvm_wr_data,
  input wire logic o_prot_prog_done,
  input wire logic o_prot_prog_reject
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  // Accepted fetch of the protection byte
  sequence s_fetch;
    o_nvm_fetch_req && i_nvm_fetch_valid;
  endsequence

  // Fetch during a retest boot at run level
  sequence s_retest;
    s_fetch ##0 (i_program_level == 3'h7 && i_retest_entry);
  endsequence

  eeprom_lock_a: assert property (
    s_retest ##0 i_nvm_fetch_data[6] |=> o_eeprom_block) else $error("eeprom lock missing");
  eeprom_gate_a: assert property (
    o_eeprom_wr_en == (i_eeprom_wr_req && !o_eeprom_block)) else $error("eeprom write leak");
  nvm_last_a: assert property (
    $rose(o_nvm_block) |-> o_boot_done && !o_boot_busy) else $error("memory lock not last");
  crc_open_a: assert property (
    i_acc_req && i_acc_op[1] |-> o_acc_grant && !o_acc_deny) else $error("crc refused");
  locked_deny_a: assert property (
    i_acc_req && o_nvm_block && !i_acc_op[1] && (i_acc_op[0] || i_acc_addr < 13'h1fc0)
    |-> o_acc_deny && !o_acc_grant) else $error("locked access granted");
  prog_reject_a: assert property (
    i_prot_prog_req && i_program_level == 3'h7 |=> o_prot_prog_reject && !o_prot_prog_done)
    else $error("run level programming taken");
  prog_write_a: assert property (
    i_prot_prog_req && i_program_level != 3'h7
    |=> o_prot_prog_done && o_prot_nvm_wr_data == $past(i_prot_prog_bits))
    else $error("programming write wrong");
  early_osc_a: assert property (
    s_fetch ##0 i_nvm_fetch_data[4] |=> o_early_oscillator_enable) else $error("osc not on");
  nonrun_a: assert property (
    s_fetch ##0 i_program_level != 3'h7 |=> !o_eeprom_block) else $error("flag used early");
endmodule

bind rbp_boot_protect rbp_boot_protect_chk rbp_boot_protect_chk_inst (.*);

`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic i_clock = 1'b0, i_reset = 1'b1, slow = 1'b0, i_boot_start = 1'b0;
  logic i_retest_entry = 1'b0, i_eeprom_wr_req = 1'b0, i_acc_req = 1'b0, i_prot_prog_req = 1'b0;
  logic [2:0] i_program_level = 3'h0;
  logic [1:0] i_acc_op = 2'h0;
  logic [12:0] i_acc_addr = 13'h0000, o_nvm_fetch_addr, o_prot_nvm_wr_addr;
  logic [7:0] i_eeprom_rd_data = 8'h00, i_prot_prog_bits = 8'h00, i_nvm_fetch_data;
  logic [7:0] o_eeprom_rd_data, o_prot_nvm_wr_data, cells;
  logic [11:0] o_ram_clear_addr;
  logic o_boot_busy, o_boot_done, o_nvm_fetch_req, i_nvm_fetch_valid, o_user_load_req;
  logic i_user_load_done, o_user_run, o_ram_clear_valid, o_ram_clear_iram, i_ram_clear_ready;
  logic o_early_oscillator_enable, o_eeprom_block, o_nvm_block, o_two_wire_debug_port_open;
  logic o_eeprom_wr_en, o_acc_grant, o_acc_deny, o_prot_nvm_wr_req, o_prot_prog_done;
  logic o_prot_prog_reject;
  int n_fail = 0, n_compared = 0, cycles = 0, clears, bad;

  rbp_boot_protect rbp_boot_protect_inst (.*);

  rbp_nvm_model rbp_nvm_model_inst (
    .i_clock(i_clock), .i_slow(slow), .i_fetch(o_nvm_fetch_req), .i_addr(o_nvm_fetch_addr),
    .o_valid(i_nvm_fetch_valid), .o_data(i_nvm_fetch_data), .i_load(o_user_load_req),
    .o_load_done(i_user_load_done), .i_clr(o_ram_clear_valid), .i_clr_iram(o_ram_clear_iram),
    .i_clr_addr(o_ram_clear_addr), .o_ready(i_ram_clear_ready), .i_wr(o_prot_nvm_wr_req),
    .i_wr_addr(o_prot_nvm_wr_addr), .i_wr_data(o_prot_nvm_wr_data), .o_cells(cells),
    .o_clears(clears), .o_bad(bad)
  );

  // 40 MHz clock
  always #12.5 i_clock = ~i_clock;

  task automatic print_verdict;
    begin
      if (n_fail == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      n_compared++;
      if (seen !== exp)
      begin
        n_fail++;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask

  // Program protection bits; refused at run level
  task automatic prog(input logic [7:0] bits, input logic [2:0] lvl);
    begin
      @(posedge i_clock);
      i_program_level <= lvl;
      i_prot_prog_req <= 1'b1;
      i_prot_prog_bits <= bits;
      @(posedge i_clock);
      i_prot_prog_req <= 1'b0;
      #1;
      check(16'({o_prot_prog_reject, o_prot_prog_done}), 16'({lvl == 3'h7, lvl != 3'h7}));
    end
  endtask

  // Start a boot and wait for its completion pulse
  task automatic boot(input logic [2:0] lvl, input logic rt);
    int n;
    begin
      @(posedge i_clock);
      i_program_level <= lvl;
      i_retest_entry <= rt;
      i_boot_start <= 1'b1;
      @(posedge i_clock);
      i_boot_start <= 1'b0;
      n = 0;
      do
      begin
        @(posedge i_clock);
        #1;
        n++;
      end
      while (o_boot_done !== 1'b1 && n < 12000);
      check(16'(o_boot_done), 16'h1);
    end
  endtask

  // Access gate decision for one operation
  task automatic gate(input logic [1:0] op, input logic [12:0] addr, input logic g);
    begin
      @(posedge i_clock);
      i_acc_req <= 1'b1;
      i_acc_op <= op;
      i_acc_addr <= addr;
      #1;
      check(16'({o_acc_grant, o_acc_deny}), 16'({g, !g}));
    end
  endtask

  // EEPROM write enable and registered read data
  task automatic ee(input logic blk);
    begin
      @(posedge i_clock);
      i_eeprom_wr_req <= 1'b1;
      i_eeprom_rd_data <= 8'h5a;
      @(posedge i_clock);
      #1;
      check(16'(o_eeprom_wr_en), 16'(!blk));
      check(16'(o_eeprom_rd_data), blk ? 16'h0000 : 16'h005a);
    end
  endtask

  // Hang guard
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge i_clock);
    i_reset <= 1'b0;
    prog(8'h18, 3'h1);
    boot(3'h1, 1'b0);
    check(16'({o_early_oscillator_enable, o_user_run}), 16'h2);
    boot(3'h3, 1'b0);
    check(16'(o_user_run), 16'h0);
    prog(8'h02, 3'h3);
    boot(3'h3, 1'b0);
    check(16'(o_user_run), 16'h1);
    prog(8'he0, 3'h3);
    boot(3'h3, 1'b1);
    check(16'({o_eeprom_block, o_nvm_block, o_two_wire_debug_port_open}), 16'h0);
    ee(1'b0);
    gate(2'h1, 13'h0000, 1'b1);
    prog(8'h05, 3'h7);
    check(16'(cells), 16'h00fa);
    boot(3'h7, 1'b0);
    check(16'({o_eeprom_block, o_nvm_block, o_two_wire_debug_port_open}), 16'h0);
    slow <= 1'b1;
    boot(3'h7, 1'b1);
    check(16'(clears), 16'h0ff8);
    check(16'(bad), 16'h0000);
    check(16'({o_eeprom_block, o_nvm_block, o_two_wire_debug_port_open}), 16'h7);
    ee(1'b1);
    gate(2'h0, 13'h1fbf, 1'b0);
    gate(2'h0, 13'h1fc0, 1'b1);
    gate(2'h1, 13'h1fff, 1'b0);
    gate(2'h2, 13'h0000, 1'b1);
    gate(2'h3, 13'h0400, 1'b1);
    print_verdict();
  end
endmodule

`default_nettype wire
